// ===== hdl/pwg_pkg.sv
/*
 Constants, register map and carrier types of the PWM interrupt and
 period block. Assumes a 32-bit AHB-Lite register bus, word access only.
*/
package pwg_pkg;
   // Module-level registers
   localparam logic [11:0] MOD_INTEN = 12'h004;
   localparam logic [11:0] MOD_RIS = 12'h008;
   localparam logic [11:0] MOD_ISC = 12'h00C;
   // Generator g sits at (g + 1) * 0x40
   localparam logic [5:0] GEN_CTL = 6'h00;
   localparam logic [5:0] GEN_PERIOD = 6'h04;
   localparam logic [5:0] GEN_COUNT = 6'h08;
   localparam logic [5:0] GEN_CMPA = 6'h0C;
   localparam logic [5:0] GEN_CMPB = 6'h10;
   localparam logic [5:0] GEN_INTEN = 6'h14;
   localparam logic [5:0] GEN_RIS = 6'h18;
   localparam logic [5:0] GEN_ISC = 6'h1C;
   // Field positions
   localparam int CTL_RUN = 0;
   localparam int CTL_UP = 1;
   localparam int TRIG_LSB = 8;
   localparam int FAULT_LSB = 16;
   localparam int NEVT = 6;
   localparam int CNT_W = 16;
   // Reset values
   localparam logic [15:0] PERIOD_RST = 16'h0001;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Event bits, low to high: zero, load, A up, A down, B up, B down
   typedef struct packed {
      logic irq_cmp_b_counting_down;
      logic irq_cmp_b_counting_up;
      logic irq_cmp_a_counting_down;
      logic irq_cmp_a_counting_up;
      logic irq_on_count_load;
      logic irq_on_count_zero;
   } pwg_evt_t;

   // Latched address phase
   typedef struct packed {
      logic [11:0] addr;
      logic wr;
   } pwg_acc_t;
endpackage : pwg_pkg

// ===== hdl/pwg_top.sv
/*
 Interrupt, trigger and period logic of a multi-generator PWM module,
 with an AHB-Lite register slave. Assumes mclk is the PWM tick, one
 master, word transfers only; fault pins are asynchronous.
*/
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Generator status bits clear on written one
// - Clearing an enable bit masks that source
// - Setting an enable bit unmasks that source
// - Raw and masked generator status both readable
// - Period is ticks between counter-zero pulses
// - Period register reads back the staged value
// - Later period writes replace the staged value
// - Module enable bit per generator and fault
// - Module status readable raw and masked
module pwg_top #(
   parameter int NGEN = 4,
   parameter int NFLT = 4
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NFLT-1:0] fault_in,
   output logic [NGEN-1:0] count_zero,
   output logic [NGEN-1:0] trig_out,
   output logic irq
);

   localparam int GW = (NGEN > 1) ? $clog2(NGEN) : 1;

   // Generator regions must fit the 12-bit map above the module region
   if (NGEN < 1 || NGEN > 15) begin : gen_bad_ngen
      $error("pwg_top: NGEN must lie in 1..15");
   end
   // Fault status bits sit from bit 16 up to bit 31
   if (NFLT < 1 || NFLT > 16) begin : gen_bad_nflt
      $error("pwg_top: NFLT must lie in 1..16");
   end

   ////////////////////////////////////////////////////////////////////
   // Bus slave

   pwg_pkg::pwg_acc_t acc_q, acc_d;
   logic wact_q, wact_d;
   logic [31:0] rdat_q, rdat_d;
   logic [31:0] rmux;
   logic take;

   // Zero wait states; read data is caught on the address phase
   assign take = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdat_q;

   always_comb begin
      acc_d = acc_q;
      wact_d = 1'b0;
      rdat_d = rdat_q;
      if (take) begin
         acc_d.addr = haddr[11:0];
         acc_d.wr = hwrite;
         wact_d = hwrite;
         if (!hwrite) begin
            rdat_d = rmux;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         acc_q <= '0;
         wact_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         acc_q <= acc_d;
         wact_q <= wact_d;
         rdat_q <= rdat_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Generators

   logic [1:0] ctl_q [NGEN];
   logic [15:0] per_q [NGEN];
   logic [15:0] pact_q [NGEN];
   logic [15:0] cnt_q [NGEN];
   logic [15:0] cmpa_q [NGEN];
   logic [15:0] cmpb_q [NGEN];
   logic [5:0] ien_q [NGEN];
   logic [5:0] ten_q [NGEN];
   pwg_pkg::pwg_evt_t ris_q [NGEN];
   pwg_pkg::pwg_evt_t evt_q [NGEN];
   logic [NGEN-1:0] gen_int;

   genvar g;
   generate
      for (g = 0; g < NGEN; g++) begin : gen_g
         localparam logic [5:0] GSEL = 6'(g + 1);
         logic wsel;
         logic [5:0] off;
         logic run, up, wrap, hit_a, hit_b;
         logic [15:0] use_per;
         logic [1:0] ctl_d;
         logic [15:0] per_d, pact_d, cnt_d, cmpa_d, cmpb_d;
         logic [5:0] ien_d, ten_d;
         pwg_pkg::pwg_evt_t ev, ris_d;

         always_comb begin
            wsel = wact_q && acc_q.addr[11:6] == GSEL;
            off = acc_q.addr[5:0];
            run = ctl_q[g][pwg_pkg::CTL_RUN];
            up = ctl_q[g][pwg_pkg::CTL_UP];
            use_per = (per_q[g] == 16'h0000) ? 16'h0001 : per_q[g];
            hit_a = cnt_q[g] == cmpa_q[g];
            hit_b = cnt_q[g] == cmpb_q[g];
            ev = '0;
            if (run) begin
               ev.irq_on_count_zero = cnt_q[g] == 16'h0000;
               ev.irq_on_count_load = cnt_q[g] == pact_q[g] - 16'h0001;
               ev.irq_cmp_a_counting_up = hit_a && up;
               ev.irq_cmp_a_counting_down = hit_a && !up;
               ev.irq_cmp_b_counting_up = hit_b && up;
               ev.irq_cmp_b_counting_down = hit_b && !up;
            end
            // While running, staged period is taken only at the wrap point
            wrap = up ? (cnt_q[g] >= pact_q[g] - 16'h0001)
                      : (cnt_q[g] == 16'h0000);
            pact_d = pact_q[g];
            cnt_d = cnt_q[g];
            // Stopped: count parks at zero, active period tracks staged
            if (!run) begin
               pact_d = use_per;
               cnt_d = 16'h0000;
            end else if (wrap) begin
               pact_d = use_per;
               cnt_d = up ? 16'h0000 : use_per - 16'h0001;
            end else begin
               cnt_d = up ? cnt_q[g] + 16'h0001 : cnt_q[g] - 16'h0001;
            end
            ctl_d = ctl_q[g];
            per_d = per_q[g];
            cmpa_d = cmpa_q[g];
            cmpb_d = cmpb_q[g];
            ien_d = ien_q[g];
            ten_d = ten_q[g];
            ris_d = ris_q[g];
            if (wsel) begin
               unique case (off)
                  pwg_pkg::GEN_CTL: ctl_d = hwdata[1:0];
                  pwg_pkg::GEN_PERIOD: per_d = hwdata[15:0];
                  pwg_pkg::GEN_CMPA: cmpa_d = hwdata[15:0];
                  pwg_pkg::GEN_CMPB: cmpb_d = hwdata[15:0];
                  pwg_pkg::GEN_INTEN: begin
                     ien_d = hwdata[5:0];
                     ten_d = hwdata[pwg_pkg::TRIG_LSB +: pwg_pkg::NEVT];
                  end
                  // Either status view takes the one-to-clear write
                  pwg_pkg::GEN_RIS, pwg_pkg::GEN_ISC: begin
                     ris_d = ris_q[g] & ~hwdata[5:0];
                  end
                  default: ;
               endcase
            end
            // A new event outweighs a clear in the same cycle
            ris_d = ris_d | evt_q[g];
         end

         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               ctl_q[g] <= 2'h0;
               per_q[g] <= pwg_pkg::PERIOD_RST;
               pact_q[g] <= pwg_pkg::PERIOD_RST;
               cnt_q[g] <= 16'h0000;
               cmpa_q[g] <= 16'h0000;
               cmpb_q[g] <= 16'h0000;
               ien_q[g] <= 6'h00;
               ten_q[g] <= 6'h00;
               ris_q[g] <= '0;
               evt_q[g] <= '0;
            end else begin
               ctl_q[g] <= ctl_d;
               per_q[g] <= per_d;
               pact_q[g] <= pact_d;
               cnt_q[g] <= cnt_d;
               cmpa_q[g] <= cmpa_d;
               cmpb_q[g] <= cmpb_d;
               ien_q[g] <= ien_d;
               ten_q[g] <= ten_d;
               ris_q[g] <= ris_d;
               evt_q[g] <= ev;
            end
         end

         // Pulses and triggers come straight from the event flops
         assign count_zero[g] = evt_q[g].irq_on_count_zero;
         assign trig_out[g] = |(evt_q[g] & ten_q[g]);
         assign gen_int[g] = |(ris_q[g] & ien_q[g]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Module status, faults and interrupt

   logic [NFLT-1:0] flt_s1_q, flt_s2_q;
   logic [NFLT-1:0] fris_q, fris_d;
   logic [31:0] men_q, men_d;
   logic [31:0] mraw, mmask;
   logic mod_wr;
   logic irq_d;

   always_comb begin
      mraw = 32'h0000_0000;
      // Generator bits follow its masked status and are not writable here
      mraw[NGEN-1:0] = gen_int;
      mraw[pwg_pkg::FAULT_LSB +: NFLT] = fris_q;
      mmask = mraw & men_q;
      mod_wr = wact_q && acc_q.addr[11:6] == 6'h00;
      men_d = men_q;
      fris_d = fris_q;
      if (mod_wr && acc_q.addr == pwg_pkg::MOD_INTEN) begin
         men_d = 32'h0000_0000;
         men_d[NGEN-1:0] = hwdata[NGEN-1:0];
         men_d[pwg_pkg::FAULT_LSB +: NFLT] = hwdata[pwg_pkg::FAULT_LSB +: NFLT];
      end
      if (mod_wr && (acc_q.addr == pwg_pkg::MOD_RIS || acc_q.addr == pwg_pkg::MOD_ISC)) begin
         fris_d = fris_q & ~hwdata[pwg_pkg::FAULT_LSB +: NFLT];
      end
      // Fault status re-sets every cycle the synced level is high
      fris_d = fris_d | flt_s2_q;
      irq_d = |mmask;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flt_s1_q <= '0;
         flt_s2_q <= '0;
         fris_q <= '0;
         men_q <= 32'h0000_0000;
         irq <= 1'b0;
      end else begin
         flt_s1_q <= fault_in;
         flt_s2_q <= flt_s1_q;
         fris_q <= fris_d;
         men_q <= men_d;
         irq <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read mux on the address phase
   // A read right behind a write to the same word sees the old value

   logic [5:0] rsel, rgn;
   logic [GW-1:0] ri;

   always_comb begin
      rsel = haddr[11:6];
      rgn = rsel - 6'h01;
      ri = rgn[GW-1:0];
      rmux = pwg_pkg::WORD_ZERO;
      if (rsel == 6'h00) begin
         unique case (haddr[11:0])
            pwg_pkg::MOD_INTEN: rmux = men_q;
            pwg_pkg::MOD_RIS: rmux = mraw;
            pwg_pkg::MOD_ISC: rmux = mmask;
            default: rmux = pwg_pkg::WORD_ZERO;
         endcase
      end else if (rgn < 6'(NGEN)) begin
         unique case (haddr[5:0])
            pwg_pkg::GEN_CTL: rmux[1:0] = ctl_q[ri];
            pwg_pkg::GEN_PERIOD: rmux[15:0] = per_q[ri];
            pwg_pkg::GEN_COUNT: rmux[15:0] = cnt_q[ri];
            pwg_pkg::GEN_CMPA: rmux[15:0] = cmpa_q[ri];
            pwg_pkg::GEN_CMPB: rmux[15:0] = cmpb_q[ri];
            pwg_pkg::GEN_INTEN: begin
               rmux[5:0] = ien_q[ri];
               rmux[pwg_pkg::TRIG_LSB +: pwg_pkg::NEVT] = ten_q[ri];
            end
            pwg_pkg::GEN_RIS: rmux[5:0] = ris_q[ri];
            pwg_pkg::GEN_ISC: rmux[5:0] = ris_q[ri] & ien_q[ri];
            default: rmux = pwg_pkg::WORD_ZERO;
         endcase
      end
   end

endmodule : pwg_top

`default_nettype wire

// ===== tb/pwg_chk.sv
/*
 Port checker of the PWM interrupt and period block.
 Assumes one clock, bound to pwg_top.
*/
`timescale 1ns/100ps
`default_nettype none
module pwg_chk #(
   parameter int NGEN = 4,
   parameter int NFLT = 4
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [NFLT-1:0] fault_in,
   input wire logic [NGEN-1:0] count_zero,
   input wire logic [NGEN-1:0] trig_out,
   input wire logic irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic rd_tk;
   logic wr_tk;
   logic rst_seen_q = 1'b0;
   assign rd_tk = hsel && htrans[1] && hready && !hwrite;
   assign wr_tk = hsel && htrans[1] && hready && hwrite;
   // Set once a reset edge has passed, so flops are surely cleared
   always @(posedge mclk) begin
      rst_seen_q <= !rst_b;
   end
   ////////////////////////////////////////////////////////////////////////////////
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not OKAY");
   ready_high_a: assert property (hreadyout == 1'b1)
      else $error("slave inserted a wait state");
   rst_quiet_a: assert property (@(posedge mclk) disable iff (1'b0)
      !rst_b && rst_seen_q |-> hrdata == 32'h0 && irq == 1'b0 && trig_out == '0 && count_zero == '0)
      else $error("outputs not quiet in reset");
   rel_quiet_a: assert property (@(posedge mclk) disable iff (1'b0)
      $rose(rst_b) |-> irq == 1'b0 && trig_out == '0)
      else $error("outputs not quiet at release");
   rdata_hold_a: assert property (!rd_tk |=> $stable(hrdata))
      else $error("read data moved without a read");
   unmap_zero_a: assert property (rd_tk && haddr[5:0] > 6'h1C |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   high_bits_a: assert property ((hrdata >> (16 + NFLT)) == 32'h0)
      else $error("read data has bits above the fields");
   irq_fall_a: assert property ($fell(irq) |-> $past(wr_tk, 2) || $past(wr_tk, 3))
      else $error("interrupt dropped without a write");
   cover property ($rose(irq));
   cover property (count_zero[0]);
   cover property ($fell(fault_in[0]));
endmodule : pwg_chk
bind pwg_top pwg_chk #(.NGEN(NGEN), .NFLT(NFLT)) pwg_chk_i (.mclk(mclk), .rst_b(rst_b),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in),
   .count_zero(count_zero), .trig_out(trig_out), .irq(irq));
`default_nettype wire

// ===== tb/tb_top.sv
/*
 Self-checking bench of the PWM interrupt and period block.
 Assumes a zero-wait AHB-Lite slave and mclk at 20 MHz.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] fault_in = 4'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic [3:0] count_zero;
   logic [3:0] trig_out;
   logic [31:0] rv;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   pwg_top pwg_top_i (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in),
      .count_zero(count_zero), .trig_out(trig_out), .irq(irq));
   initial begin
      forever #25 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask : bus
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rv);
   endtask : rchk
   // Counts cycles up to the next zero pulse of generator 0
   task automatic wcz();
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (count_zero[0] !== 1'b1 && n < 200);
   endtask : wcz
   task automatic irqchk(input logic e);
      repeat (3) @(negedge mclk);
      chk("irq", 32'(e), 32'(irq));
   endtask : irqchk
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      chk("rst_rdata", 32'h0, hrdata);
      rst_b <= 1'b1;
      rchk("period_rst", 12'h044, 32'h1);
      rchk("inten_rst", 12'h054, 32'h0);
      bus(1'b1, 12'h044, 32'h7);
      bus(1'b1, 12'h044, 32'h4);
      rchk("period_rd", 12'h044, 32'h4);
      bus(1'b1, 12'h054, 32'h101);
      bus(1'b1, 12'h040, 32'h1);
      wcz();
      wcz();
      chk("period4", 32'h4, 32'(n));
      chk("trig", 32'h1, 32'(trig_out[0]));
      // Long period first, so both later writes land inside one period
      bus(1'b1, 12'h044, 32'h20);
      bus(1'b1, 12'h044, 32'h6);
      bus(1'b1, 12'h044, 32'h3);
      rchk("staged", 12'h044, 32'h3);
      wcz();
      wcz();
      wcz();
      chk("period3", 32'h3, 32'(n));
      bus(1'b1, 12'h040, 32'h3);
      wcz();
      wcz();
      wcz();
      chk("period_up", 32'h3, 32'(n));
      bus(1'b1, 12'h040, 32'h0);
      rchk("gen_raw", 12'h058, 32'h3F);
      rchk("gen_mask", 12'h05C, 32'h01);
      rchk("mod_raw", 12'h008, 32'h1);
      irqchk(1'b0);
      bus(1'b1, 12'h004, 32'h1);
      irqchk(1'b1);
      rchk("mod_mask", 12'h00C, 32'h1);
      bus(1'b1, 12'h058, 32'h0);
      rchk("w0_keep", 12'h058, 32'h3F);
      bus(1'b1, 12'h05C, 32'h1);
      rchk("w1_clr", 12'h058, 32'h3E);
      irqchk(1'b0);
      rchk("mod_clr", 12'h008, 32'h0);
      fault_in <= 4'h1;
      repeat (4) @(posedge mclk);
      fault_in <= 4'h0;
      repeat (4) @(posedge mclk);
      rchk("flt_raw", 12'h008, 32'h10000);
      irqchk(1'b0);
      bus(1'b1, 12'h004, 32'h10001);
      irqchk(1'b1);
      rchk("flt_mask", 12'h00C, 32'h10000);
      bus(1'b1, 12'h00C, 32'h10000);
      rchk("flt_clr", 12'h008, 32'h0);
      irqchk(1'b0);
      rchk("unmapped", 12'h03C, 32'h0);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      rchk("period_rst2", 12'h044, 32'h1);
      rchk("men_rst", 12'h004, 32'h0);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
